// file: logic/csw_cam.sv
`timescale 1ns/1ps
module csw_cam #(
    parameter int                            WORDS     = csw_pkg::CSW_WORDS,
    parameter logic [csw_pkg::CSW_WIDTH-1:0] INIT_DATA = 32'h0000_0000,
    parameter logic [csw_pkg::CSW_WIDTH-1:0] INIT_CARE = 32'hffff_ffff
) (
    input  wire logic                            clock,    // block clock
    input  wire logic                            rstn,     // sync reset, low
    input  wire csw_pkg::csw_wr_s                wr,       // write request
    output logic                                 wr_done,  // write committed
    input  wire logic                            srch,     // search strobe
    input  wire logic [csw_pkg::CSW_WIDTH-1:0]   key,      // search word
    input  wire logic                            unenc,    // 1 = one-hot output
    output csw_pkg::csw_res_s                    res,      // search result
    output logic                                 multi     // more than one hit
);
    import csw_pkg::*;

    // array contents start from the preload values, no reset touches them
    logic [CSW_WIDTH-1:0]  mem_data [WORDS] = '{default: INIT_DATA};
    logic [CSW_WIDTH-1:0]  mem_care [WORDS] = '{default: INIT_CARE};
    logic [CSW_WIDTH-1:0]  next_mem_data [WORDS];
    logic [CSW_WIDTH-1:0]  next_mem_care [WORDS];
    csw_wst_e              wst;
    csw_wst_e              next_wst;
    logic                  next_wr_done;
    logic                  commit;
    logic [WORDS-1:0]      hits;
    logic                  hit_any;
    logic                  hit_many;
    logic [CSW_ADDR_W-1:0] hit_addr;
    logic [WORDS-1:0]      hold_hits;
    logic [WORDS-1:0]      next_hold_hits;
    logic                  half_pend;
    logic                  next_half_pend;
    logic                  enc_match;
    logic                  next_enc_match;
    logic [CSW_ADDR_W-1:0] enc_addr;
    logic [CSW_ADDR_W-1:0] next_enc_addr;
    logic                  next_multi;
    logic [CSW_HALF_W-1:0] lines;
    logic [CSW_HALF_W-1:0] next_lines;
    logic                  upper;
    logic                  next_upper;
    logic                  lines_valid;
    logic                  next_lines_valid;

    // one entry compare, masked bits ignored
    function automatic logic hit_f(input logic [CSW_WIDTH-1:0] d,
                                   input logic [CSW_WIDTH-1:0] c,
                                   input logic [CSW_WIDTH-1:0] k);
        hit_f = ((d ^ k) & ~c) == '0;
    endfunction

    // index of lowest set bit
    function automatic logic [CSW_ADDR_W-1:0] enc_f(input logic [WORDS-1:0] v);
        enc_f = '0;
        for (int i = WORDS - 1; i >= 0; i--) begin
            if (v[i]) begin
                enc_f = CSW_ADDR_W'(i);
            end
        end
    endfunction

    // one sixteen-line half of a hit vector
    function automatic logic [CSW_HALF_W-1:0] half_f(input logic [WORDS-1:0] v,
                                                     input logic             up);
        half_f = up ? v[WORDS-1 -: CSW_HALF_W] : v[CSW_HALF_W-1:0];
    endfunction

    // parallel compare of all entries
    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            hits[i] = hit_f(mem_data[i], mem_care[i], key);
        end
    end

    // search summary: any hit, several hits, lowest index
    always_comb begin
        hit_any  = |hits;
        hit_many = $countones(hits) > 1;
        hit_addr = hit_any ? enc_f(hits) : '0;
    end

    // write sequencer: two cycles, three with mask
    always_comb begin
        next_wst     = wst;
        next_wr_done = 1'b0;
        commit       = 1'b0;
        case (wst)
            CSW_IDLE: begin
                if (wr.req) begin
                    next_wst = CSW_WDATA;
                end
            end
            CSW_WDATA: begin
                if (!wr.req) begin
                    next_wst = CSW_IDLE;
                end else if (wr.use_mask) begin
                    next_wst = CSW_WMASK;
                end else begin
                    commit       = 1'b1;
                    next_wr_done = 1'b1;
                    next_wst     = CSW_IDLE;
                end
            end
            CSW_WMASK: begin
                commit       = wr.req;
                next_wr_done = wr.req;
                next_wst     = CSW_IDLE;
            end
            default: begin
                next_wst = CSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            wst     <= CSW_IDLE;
            wr_done <= 1'b0;
        end else begin
            wst     <= next_wst;
            wr_done <= next_wr_done;
        end
    end

    // array storage: only the addressed entry takes the run-time write
    always_comb begin
        for (int i = 0; i < WORDS; i++) begin
            next_mem_data[i] = mem_data[i];
            next_mem_care[i] = mem_care[i];
            if (commit && (wr.addr == CSW_ADDR_W'(i))) begin
                next_mem_data[i] = wr.data;
                // a plain write clears the mask, so every bit is compared
                next_mem_care[i] = wr.use_mask ? wr.care_n : '0;
            end
        end
    end

    // array registers: no reset, so the preload survives a reset
    always_ff @(posedge clock) begin
        for (int i = 0; i < WORDS; i++) begin
            mem_data[i] <= next_mem_data[i];
            mem_care[i] <= next_mem_care[i];
        end
    end

    // encoded view: held until the next search
    always_comb begin
        next_enc_match = enc_match;
        next_enc_addr  = enc_addr;
        next_multi     = multi;
        if (srch) begin
            next_enc_match = hit_any;
            // address is the lowest hit index, or zero without a match
            next_enc_addr  = hit_addr;
            next_multi     = hit_many;
        end
    end

    // encoded view registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            enc_match <= 1'b0;
            enc_addr  <= '0;
            multi     <= 1'b0;
        end else begin
            enc_match <= next_enc_match;
            enc_addr  <= next_enc_addr;
            multi     <= next_multi;
        end
    end

    // unencoded view: low half, then high half on the next cycle
    always_comb begin
        next_lines       = lines;
        next_upper       = upper;
        next_lines_valid = 1'b0;
        next_hold_hits   = hold_hits;
        next_half_pend   = 1'b0;
        if (half_pend) begin
            next_lines       = half_f(hold_hits, 1'b1);
            next_upper       = 1'b1;
            next_lines_valid = 1'b1;
        end
        if (srch) begin
            next_hold_hits = hits;
            // a new unencoded search overrides a pending high half
            if (unenc) begin
                next_lines       = half_f(hits, 1'b0);
                next_upper       = 1'b0;
                next_lines_valid = 1'b1;
                next_half_pend   = 1'b1;
            end
        end
    end

    // unencoded view registers
    always_ff @(posedge clock) begin
        if (!rstn) begin
            lines       <= '0;
            upper       <= 1'b0;
            lines_valid <= 1'b0;
            hold_hits   <= '0;
            half_pend   <= 1'b0;
        end else begin
            lines       <= next_lines;
            upper       <= next_upper;
            lines_valid <= next_lines_valid;
            hold_hits   <= next_hold_hits;
            half_pend   <= next_half_pend;
        end
    end

    // result bundle, every field straight from a flip-flop
    always_comb begin
        res.match       = enc_match;
        res.addr        = enc_addr;
        res.lines       = lines;
        res.upper       = upper;
        res.lines_valid = lines_valid;
    end
endmodule

// file: logic/csw_pkg.sv
package csw_pkg;
    // geometry of the content-addressable array
    localparam int CSW_WORDS      = 32;
    localparam int CSW_WIDTH      = 32;
    localparam int CSW_ADDR_W     = 5;
    localparam int CSW_HALF_W     = 16;
    // cycles a write occupies, plain and with don't-care mask
    localparam int CSW_WR_CYCLES  = 2;
    localparam int CSW_WRM_CYCLES = 3;
    localparam logic [1:0] CSW_CNT_ZERO = 2'h0;

    // write request as the fabric presents it
    typedef struct packed {
        logic                    req;
        logic                    use_mask;
        logic [CSW_ADDR_W-1:0]   addr;
        logic [CSW_WIDTH-1:0]    data;
        logic [CSW_WIDTH-1:0]    care_n;   // 1 = don't-care bit
    } csw_wr_s;

    // search result
    typedef struct packed {
        logic                    match;
        logic [CSW_ADDR_W-1:0]   addr;
        logic [CSW_HALF_W-1:0]   lines;
        logic                    upper;    // lines show entries 16..31
        logic                    lines_valid;
    } csw_res_s;

    typedef enum logic [1:0] {
        CSW_IDLE  = 2'b00,
        CSW_WDATA = 2'b01,
        CSW_WMASK = 2'b10
    } csw_wst_e;
endpackage

// file: dv/csw_chk.sv
`timescale 1ns/1ps
// port checks of the cam block
module csw_chk
    import csw_pkg::*;
(
    input wire logic             clock,   // block clock
    input wire logic             rstn,    // sync reset, low
    input wire csw_pkg::csw_wr_s wr,      // write request
    input wire logic             wr_done, // write committed
    input wire logic             srch,    // search strobe
    input wire logic             unenc,   // one-hot select
    input wire csw_pkg::csw_res_s res,    // result
    input wire logic             multi    // several hits
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // writes started from an idle request line
    sequence s_pl; !wr.req ##1 (wr.req && !wr.use_mask)[*2]; endsequence
    sequence s_mk; !wr.req ##1 (wr.req && wr.use_mask)[*2]; endsequence
    plain_wr_a: assert property (s_pl |=> wr_done)
        else $error("plain write not done");
    mask_wr_a: assert property (s_mk ##1 (wr.req && wr.use_mask) |=> wr_done)
        else $error("mask write not done");
    mask_early_a: assert property (s_mk |=> !wr_done)
        else $error("mask write done early");
    abort_wr_a: assert property (!wr.req ##1 wr.req ##1 !wr.req |=> !wr_done)
        else $error("aborted write done");
    low_half_a: assert property (srch && unenc |=> res.lines_valid && !res.upper)
        else $error("low half missing");
    high_half_a: assert property (srch && unenc ##1 !srch |=> res.lines_valid && res.upper)
        else $error("high half missing");
    enc_only_a: assert property (!(srch && unenc) ##1 (srch && !unenc) |=> !res.lines_valid)
        else $error("lines in encoded mode");
    no_hit_a: assert property (!res.match |-> res.addr == 5'h0 && !multi)
        else $error("result without match");
    hit_flag_a: assert property (res.lines_valid && res.lines != 16'h0 |-> res.match)
        else $error("line high without match");
endmodule
bind csw_cam csw_chk chk_u (.clock, .rstn, .wr, .wr_done, .srch, .unenc, .res, .multi);

// file: dv/csw_fab.sv
`timescale 1ns/1ps
// fabric writer: holds each request for the n cycles the caller asks for
module csw_fab
    import csw_pkg::*;
(
    input  wire logic        clock,   // block clock
    input  wire logic        wr_done, // write committed
    output csw_pkg::csw_wr_s wr       // write request
);
    initial wr = '0;
    // hold n cycles, then release with inverted payload
    task automatic put(input logic m, input logic [4:0] a, input logic [31:0] d, c,
                       input int n, output logic done);
        @(posedge clock);
        #1 wr = {1'b1, m, a, d, c};
        repeat (n) @(posedge clock);
        #1 done = wr_done;
        wr = {2'b00, ~a, ~d, ~c};
    endtask
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import csw_pkg::*;
    logic        clock = 0, rstn = 0, srch = 0, unenc = 0, wr_done, multi, done;
    logic [31:0] key = '0, enc, ln;
    logic [3:0]  ph;
    csw_wr_s     wr;
    csw_res_s    res;
    int          n_fail = 0, checks_done = 0;
    // clock, design and writer
    always #20 clock = ~clock;
    csw_cam dut_u (.clock, .rstn, .wr, .wr_done, .srch, .key, .unenc, .res, .multi);
    csw_fab fab_u (.clock, .wr_done, .wr);
    // compare and count
    task chk(input logic [31:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one search: encoded view, then both line halves
    task look(input logic [31:0] k, input logic u);
        @(posedge clock);
        #1 {srch, key, unenc} = {1'b1, k, u};
        @(posedge clock);
        #1 srch = 0;
        enc = 32'({res.match, multi, res.addr});
        ln[15:0] = res.lines;
        ph[1:0] = {res.lines_valid, res.upper};
        @(posedge clock);
        #1 ln[31:16] = res.lines;
        ph[3:2] = {res.lines_valid, res.upper};
    endtask
    task t_preload;
        look(32'h1234_5678, 1'b1);
        chk(enc, 32'h60);
        chk(ln, 32'hffff_ffff);
        chk(32'(ph), 32'he);
        $display("end preload");
    endtask
    task t_write;
        for (int i = 0; i < 32; i++) begin
            fab_u.put(1'b0, i[4:0], 32'h100 + i, 32'h0, 2, done);
            chk({31'h0, done}, 32'h1);
        end
        look(32'h11f, 1'b1);
        chk(enc, 32'h5f);
        chk(ln, 32'h8000_0000);
        $display("end write");
    endtask
    task t_mask;
        fab_u.put(1'b1, 5'h7, 32'h0, 32'hff, 2, done);
        chk({31'h0, done}, 32'h0);
        fab_u.put(1'b1, 5'h5, 32'h0, 32'hff, 3, done);
        chk({31'h0, done}, 32'h1);
        fab_u.put(1'b0, 5'h9, 32'hab, 32'h0, 1, done);
        look(32'hab, 1'b0);
        chk(enc, 32'h45);
        chk(32'({ph[3], ph[1]}), 32'h0);
        $display("end mask");
    endtask
    task t_dup;
        fab_u.put(1'b0, 5'h9, 32'h100, 32'h0, 2, done);
        look(32'h100, 1'b1);
        chk(enc, 32'h60);
        chk(ln, 32'h0000_0201);
        look(32'hdead_beef, 1'b0);
        chk(enc, 32'h0);
        $display("end duplicate");
    endtask
    initial begin
        repeat (8) @(posedge clock);
        #1 rstn = 1;
        t_preload;
        t_write;
        t_mask;
        t_dup;
        test_done;
    end
    initial begin
        #50000;
        n_fail++;
        test_done;
    end
endmodule
